/* File: design/adc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - first read-and-clear returns result, clears flag
// - second read-and-clear returns result, clears flag
// - all clears act on one shared flag
// - flag clearable alone without reading results
// - results overwritten at every conversion end
// - bit 4 switch: 0 disables, 1 enables
// - first word 0x90, third word 0x60
// - fourth word bits 7:5 set, 3:0 clear
// - second word: input select bits 7:5
// - second channel uses identical word layout
// - compare equals two to depth plus two
// - period equals calculation interval plus compare
// - integrator pulse stream counted per channel
// - sample count zero runs continuously
// - status reads non-zero once results ready
// - 8-bit sample count, stop when reached
// - depth 7 to 13, write stops conversion
module adc_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [ADDR_W-1:0]        s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [CHANNELS-1:0]      comparator_in,
  output logic [CHANNELS-1:0]           integrator_enable_switch,
  output logic [CHANNELS-1:0][3:0][7:0] config_words,
  output logic                          converting
);
  // ****************************************
  // bus decode
  // ****************************************
  wire        wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire        rd_fire = s_axi_arvalid && !s_axi_rvalid;
  wire [7:0]  wr_addr = s_axi_awaddr[7:0];
  wire [7:0]  rd_addr = s_axi_araddr[7:0];
  wire        wr_acq   = wr_fire && (wr_addr == ADDR_ACQUIRE);
  wire        wr_depth = wr_fire && (wr_addr == ADDR_DEPTH);
  wire        wr_calc  = wr_fire && (wr_addr == ADDR_CALC);
  wire        wr_clear = wr_fire && (wr_addr == ADDR_CLEAR);
  wire        rd_clr1  = rd_fire && (rd_addr == ADDR_RD1_CLR);
  wire        rd_clr2  = rd_fire && (rd_addr == ADDR_RD2_CLR);
  wire        depth_ok = (s_axi_wdata[3:0] >= DEPTH_MIN) && (s_axi_wdata[3:0] <= DEPTH_MAX);

  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = !s_axi_rvalid;

  // ****************************************
  // control registers
  // ****************************************
  seq_state_t                      state;
  seq_state_t                      next_state;
  logic [3:0]                      bit_depth;
  logic [15:0]                     calc_interval;
  logic [7:0]                      remaining;
  logic                            continuous;
  logic                            flag;
  logic signed [CHANNELS-1:0][15:0] result;
  timer_cfg_t                      tcfg;
  timer_state_t                    tstate;
  wire                             run = (state == SEQ_RUN);
  wire                             conv_end = tstate.integ_end;
  wire                             last_cycle = tstate.cycle_end && !continuous && (remaining == 8'h01);
  wire [15:0]                      half = 16'(32'd1 << (bit_depth - 4'h1));

  assign tcfg.compare = 16'(32'd1 << (bit_depth + COMPARE_EXTRA));
  assign tcfg.period  = calc_interval + tcfg.compare;
  assign converting   = run;

  integration_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (run),
    .cfg     (tcfg),
    .tstate  (tstate)
  );

  // halt and depth writes take priority over the count running out
  always_comb begin
    next_state = state;
    case (state)
      SEQ_IDLE: begin
        if (wr_acq && !s_axi_wdata[HALT_BIT]) begin
          next_state = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (wr_depth || (wr_acq && s_axi_wdata[HALT_BIT]) || last_cycle) begin
          next_state = SEQ_IDLE;
        end
      end
      default: next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state         <= SEQ_IDLE;
      bit_depth     <= DEPTH_RESET;
      calc_interval <= CALC_RESET;
      remaining     <= 8'h00;
      continuous    <= 1'b0;
    end else begin
      state <= next_state;
      if (wr_depth && depth_ok && s_axi_wstrb[0]) begin
        bit_depth <= s_axi_wdata[3:0];
      end
      if (wr_calc) begin
        calc_interval[7:0]  <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : calc_interval[7:0];
        calc_interval[15:8] <= s_axi_wstrb[1] ? s_axi_wdata[15:8] : calc_interval[15:8];
      end
      if (wr_acq && !s_axi_wdata[HALT_BIT]) begin
        remaining  <= s_axi_wdata[7:0];
        continuous <= (s_axi_wdata[7:0] == 8'h00);
      end else if (tstate.cycle_end && !continuous && remaining != 8'h00) begin
        remaining <= remaining - 8'h01;
      end
    end
  end

  // ****************************************
  // shared completion flag
  // ****************************************
  // a conversion end in the clearing cycle keeps the flag set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 1'b0;
    end else begin
      flag <= conv_end || (flag && !(wr_clear || rd_clr1 || rd_clr2));
    end
  end

  // ****************************************
  // per-channel integrator control
  // ****************************************
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    logic [1:0]  sync;
    logic [15:0] pulses;
    logic [15:0] next_pulses;
    logic [2:0]  input_select;
    logic        sw;
    wire  [7:0]  base = 8'(ch * CHAN_STRIDE);
    wire         wr_input  = wr_fire && (wr_addr == base + ADDR_INPUT) && s_axi_wstrb[0];
    wire         wr_switch = wr_fire && (wr_addr == base + ADDR_SWITCH) && s_axi_wstrb[0];
    wire         hit = tstate.integrating && sync[1];

    // only the second stage feeds the counter
    assign next_pulses = tstate.cycle_start ? {15'h0000, hit} : pulses + {15'h0000, hit};

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync         <= 2'b00;
        pulses       <= 16'h0000;
        input_select <= MUX_RESET;
        sw           <= 1'b0;
        result[ch]   <= 16'h0000;
      end else begin
        sync   <= {sync[0], comparator_in[ch]};
        pulses <= next_pulses;
        if (wr_input) begin
          input_select <= s_axi_wdata[MUX_LSB +: 3];
        end
        // sequencer owns the switch while running; software steers it when idle
        if (tstate.cycle_start) begin
          sw <= 1'b1;
        end else if (conv_end) begin
          sw <= 1'b0;
        end else if (wr_switch && !run) begin
          sw <= s_axi_wdata[SWITCH_BIT];
        end
        if (conv_end) begin
          result[ch] <= {2'b00, next_pulses[15:2]} - half;
        end
      end
    end

    assign integrator_enable_switch[ch] = sw;
    assign config_words[ch][0] = FIXED_A_WORD;
    assign config_words[ch][1] = {input_select, 5'b00000};
    assign config_words[ch][2] = FIXED_C_WORD;
    assign config_words[ch][3] = SWITCH_FIXED | {3'b000, sw, 4'b0000};
  end

  // ****************************************
  // read mux and responses
  // ****************************************
  logic [31:0] rd_data;
  logic        rd_err;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (rd_addr < ADDR_CHAN_END) begin
      rd_data = {24'h00_0000, config_words[rd_addr[4]][rd_addr[3:2]]};
    end else begin
      case (rd_addr)
        ADDR_ACQUIRE: rd_data = {23'h00_0000, continuous, remaining};
        ADDR_DEPTH:   rd_data = {28'h000_0000, bit_depth};
        ADDR_CALC:    rd_data = {16'h0000, calc_interval};
        ADDR_STATUS:  rd_data = {30'h0000_0000, run, flag};
        ADDR_CLEAR:   rd_data = 32'h0000_0000;
        ADDR_RESULT1: rd_data = {16'h0000, result[0]};
        ADDR_RESULT2: rd_data = {16'h0000, result[1]};
        ADDR_RD1_CLR: rd_data = {16'h0000, result[0]};
        ADDR_RD2_CLR: rd_data = {16'h0000, result[1]};
        ADDR_TIMER:   rd_data = {tcfg.period, tcfg.compare};
        default:      rd_err  = 1'b1;
      endcase
    end
  end

  wire wr_err = (wr_addr > ADDR_TIMER) || (wr_addr[1:0] != 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_rd1_clear_flag: assert property (rd_clr1 && !conv_end |=> !flag)
    else $error("first read-and-clear left flag set");
  chk_rd2_clear_flag: assert property (rd_clr2 && !conv_end |=> !flag && s_axi_rvalid)
    else $error("second read-and-clear left flag set");
  chk_clear_only: assert property (wr_clear && !conv_end |=> !flag && s_axi_bvalid)
    else $error("clear write left flag set");
  chk_end_sets_flag: assert property (conv_end |=> flag && !integrator_enable_switch[0])
    else $error("conversion end did not set flag");
  chk_result_hold: assert property (!conv_end |=> $stable(result))
    else $error("result changed outside conversion end");
  chk_switch_word: assert property (config_words[1][3][7:5] == 3'b111 && config_words[1][3][3:0] == 4'h0
                                    && config_words[1][3][4] == integrator_enable_switch[1])
    else $error("switch word fixed bits wrong");
  chk_compare_period: assert property (tcfg.period - tcfg.compare == calc_interval
                                       && tcfg.compare == (16'h0004 << (bit_depth - 4'h0)))
    else $error("timer period or compare wrong");
  chk_depth_stops: assert property (wr_depth |=> !converting)
    else $error("depth write did not stop conversion");
  // a stop written in the cycle after the wrap may end the run legally
  chk_continuous_run: assert property (run && continuous && tstate.cycle_end && !wr_depth && !wr_acq
                                       |=> converting ##1 (converting || $past(wr_depth || wr_acq)))
    else $error("continuous mode stopped");
  chk_last_sample_stop: assert property (last_cycle |=> !converting)
    else $error("counted mode did not stop");

  // ****************************************
  // checks on the read path and the shared flag
  // ****************************************
  // read data is the value that stood at the taking edge, upper half zero
  chk_rd1_data: assert property (rd_clr1 |=> s_axi_rdata == {16'h0000, $past(result[0])})
    else $error("first read-and-clear returned wrong data");
  chk_rd2_data: assert property (rd_clr2 |=> s_axi_rdata == {16'h0000, $past(result[1])})
    else $error("second read-and-clear returned wrong data");
  chk_status_read: assert property (rd_fire && rd_addr == ADDR_STATUS |=> s_axi_rdata[0] == $past(flag))
    else $error("status read did not show the flag");
  chk_any_clear: assert property ((wr_clear || rd_clr1 || rd_clr2) && !conv_end |=> !flag)
    else $error("a clear left the shared flag set");
  chk_flag_source: assert property ($rose(flag) |-> $past(conv_end))
    else $error("flag rose without a conversion end");

  // ****************************************
  // checks on the sequencer and config words
  // ****************************************
  chk_fixed_words: assert property (config_words[0][0] == 8'h90 && config_words[0][2] == 8'h60)
    else $error("fixed config words wrong");
  chk_second_words: assert property (config_words[1][0] == config_words[0][0]
                                     && config_words[1][2] == config_words[0][2])
    else $error("second channel fixed words differ");
  chk_input_low: assert property (config_words[0][1][4:0] == 5'h00 && config_words[1][1][4:0] == 5'h00)
    else $error("input select low bits not zero");
  // software writes must not steer one channel away from the other mid-run
  chk_switch_pair: assert property (run && $past(run)
                                    |-> integrator_enable_switch[0] == integrator_enable_switch[1])
    else $error("channel switches differ while running");
  chk_switch_open: assert property (run && tstate.integrating && !tstate.cycle_start
                                    |-> integrator_enable_switch == 2'b11)
    else $error("integrator disabled inside integration");
  chk_switch_close: assert property (conv_end |=> integrator_enable_switch == 2'b00)
    else $error("integrator left enabled after conversion end");
  chk_count_down: assert property (run && tstate.cycle_end && !continuous && remaining > 8'h01 && !wr_acq
                                   |=> remaining == $past(remaining) - 8'h01)
    else $error("sample count did not step down");
  chk_start_runs: assert property (!run && wr_acq && !s_axi_wdata[HALT_BIT] |=> converting)
    else $error("acquisition start did not run");
  chk_zero_continuous: assert property (wr_acq && !s_axi_wdata[HALT_BIT] && s_axi_wdata[7:0] == 8'h00
                                        |=> continuous)
    else $error("zero sample count did not select continuous mode");
  chk_halt_stops: assert property (wr_acq && s_axi_wdata[HALT_BIT] |=> !converting)
    else $error("halt did not stop conversion");
  chk_depth_range: assert property (bit_depth >= 4'h7 && bit_depth <= 4'hD)
    else $error("bit depth outside its range");

  // ****************************************
  // cover points
  // ****************************************
  cov_conversion_end: cover property (run ##[1:300] conv_end ##1 flag);
  cov_read_clear: cover property (flag ##1 rd_clr1 ##1 !flag);
  cov_set_wins: cover property (conv_end && wr_clear ##1 flag);
  cov_continuous_wrap: cover property (run && continuous && tstate.cycle_end ##1 converting);
  cov_counted_stop: cover property (last_cycle ##1 !converting);
endmodule : adc_ctrl
`default_nettype wire

/* File: inc/adc_ctrl_pkg.sv */
`default_nettype none
package adc_ctrl_pkg;
  // ****************************************
  // channel and register map
  // ****************************************
  localparam int unsigned CHANNELS      = 2;
  localparam int unsigned CHAN_STRIDE   = 16;
  localparam logic [7:0]  ADDR_FIXED_A  = 8'h00;
  localparam logic [7:0]  ADDR_INPUT    = 8'h04;
  localparam logic [7:0]  ADDR_FIXED_C  = 8'h08;
  localparam logic [7:0]  ADDR_SWITCH   = 8'h0C;
  localparam logic [7:0]  ADDR_CHAN_END = 8'h20;
  localparam logic [7:0]  ADDR_ACQUIRE  = 8'h20;
  localparam logic [7:0]  ADDR_DEPTH    = 8'h24;
  localparam logic [7:0]  ADDR_CALC     = 8'h28;
  localparam logic [7:0]  ADDR_STATUS   = 8'h2C;
  localparam logic [7:0]  ADDR_CLEAR    = 8'h30;
  localparam logic [7:0]  ADDR_RESULT1  = 8'h34;
  localparam logic [7:0]  ADDR_RESULT2  = 8'h38;
  localparam logic [7:0]  ADDR_RD1_CLR  = 8'h3C;
  localparam logic [7:0]  ADDR_RD2_CLR  = 8'h40;
  localparam logic [7:0]  ADDR_TIMER    = 8'h44;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam logic [7:0]  FIXED_A_WORD  = 8'h90;
  localparam logic [7:0]  FIXED_C_WORD  = 8'h60;
  localparam logic [7:0]  SWITCH_FIXED  = 8'hE0;
  localparam int unsigned SWITCH_BIT    = 4;
  localparam int unsigned MUX_LSB       = 5;
  localparam logic [2:0]  MUX_RESET     = 3'h0;
  localparam int unsigned HALT_BIT      = 8;
  localparam logic [3:0]  DEPTH_MIN     = 4'h7;
  localparam logic [3:0]  DEPTH_MAX     = 4'hD;
  localparam logic [3:0]  DEPTH_RESET   = 4'hA;
  localparam logic [3:0]  COMPARE_EXTRA = 4'h2;
  localparam logic [15:0] CALC_RESET    = 16'h0010;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN  = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic [15:0] compare;
    logic [15:0] period;
  } timer_cfg_t;

  typedef struct packed {
    logic        cycle_start;
    logic        integrating;
    logic        integ_end;
    logic        cycle_end;
    logic [15:0] count;
  } timer_state_t;
endpackage : adc_ctrl_pkg
`default_nettype wire

/* File: design/integration_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module integration_timer
  import adc_ctrl_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         run,
  input  wire timer_cfg_t   cfg,
  output var  timer_state_t tstate
);
  logic [15:0] count;
  wire         wrap = (count == cfg.period - 16'h0001);

  // ****************************************
  // up counter, integrate then compute
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count <= 16'h0000;
    end else if (wrap) begin
      count <= 16'h0000;
    end else begin
      count <= count + 16'h0001;
    end
  end

  assign tstate.count       = count;
  assign tstate.cycle_start = run && (count == 16'h0000);
  assign tstate.integrating = run && (count < cfg.compare);
  assign tstate.integ_end   = run && (count == cfg.compare - 16'h0001);
  assign tstate.cycle_end   = run && wrap;
endmodule : integration_timer
`default_nettype wire

/* File: sim/adc_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_tb_top import adc_ctrl_pkg::*;
;
  logic                 aclk = 1'b0;
  logic                 aresetn;
  logic [7:0]           s_axi_awaddr;
  logic [7:0]           s_axi_araddr;
  logic                 s_axi_awvalid;
  logic                 s_axi_wvalid;
  logic                 s_axi_bready;
  logic                 s_axi_arvalid;
  logic                 s_axi_rready;
  logic [31:0]          s_axi_wdata;
  logic [3:0]           s_axi_wstrb;
  logic                 s_axi_awready;
  logic                 s_axi_wready;
  logic                 s_axi_bvalid;
  logic                 s_axi_arready;
  logic                 s_axi_rvalid;
  logic [1:0]           s_axi_bresp;
  logic [1:0]           s_axi_rresp;
  logic [31:0]          s_axi_rdata;
  logic [1:0]           comparator_in;
  logic [1:0]           integrator_enable_switch;
  logic [1:0][3:0][7:0] config_words;
  logic                 converting;
  logic [31:0]          cap_d;
  logic [1:0]           cap_r;
  int                   n_mismatch = 0;
  int                   check_count = 0;

  always #20 aclk = ~aclk;

  adc_ctrl #(.ADDR_W(8)) adc_ctrl_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .comparator_in, .integrator_enable_switch, .config_words, .converting
  );

  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // sampled on the falling edge, so the value is the one the rising edge takes
  // no local limit: only the watchdog ends a wait for the answer
  task automatic hs(input int w);
    logic hit;
    do begin
      @(negedge aclk);
      hit = (w == 0) ? s_axi_awready : (w == 1) ? s_axi_bvalid : (w == 2) ? s_axi_arready : s_axi_rvalid;
      cap_d = s_axi_rdata;
      cap_r = (w == 1) ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
    end while (hit !== 1'b1);
  endtask : hs

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    hs(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    s_axi_bready  <= 1'b1;
    hs(1);
    s_axi_bready  <= 1'b0;
    chk("bresp", {30'h0, cap_r}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    hs(2);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    hs(3);
    s_axi_rready  <= 1'b0;
  endtask : rd

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, cap_d, e);
  endtask : rchk

  // polling stays well inside the calculation window, so no result is missed
  task automatic wait_flag();
    do begin
      rd(ADDR_STATUS);
    end while (cap_d[0] !== 1'b1);
  endtask : wait_flag

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] rv [4] = '{8'h90, 8'h00, 8'h60, 8'hE0};
    for (int c = 0; c < 2; c++) begin
      for (int w = 0; w < 4; w++) begin
        rchk("word", 8'(c * CHAN_STRIDE + w * 4), {24'h0, rv[w]});
        chk("port word", {24'h0, config_words[c][w]}, {24'h0, rv[w]});
      end
    end
    rchk("depth", ADDR_DEPTH, 32'h0000_000A);
    rchk("calc", ADDR_CALC, 32'h0000_0010);
    rchk("timer", ADDR_TIMER, 32'h1010_1000);
    rchk("status", ADDR_STATUS, 32'h0000_0000);
    rd(8'h48);
    chk("rresp", {30'h0, cap_r}, {30'h0, RESP_SLVERR});
    wr(8'h4C, 32'h0000_0000, RESP_SLVERR);
  endtask : t_reset

  task automatic t_regs();
    wr(ADDR_INPUT, 32'h0000_00FF);
    rchk("input1", ADDR_INPUT, 32'h0000_00E0);
    chk("input1 port", {24'h0, config_words[0][1]}, 32'h0000_00E0);
    wr(8'h14, 32'h0000_0040);
    rchk("input2", 8'h14, 32'h0000_0040);
    wr(ADDR_FIXED_A, 32'h0000_0000);
    rchk("fixed a", ADDR_FIXED_A, 32'h0000_0090);
    wr(ADDR_SWITCH, 32'h0000_00FF);
    rchk("switch", ADDR_SWITCH, 32'h0000_00F0);
    chk("switch on", {30'h0, integrator_enable_switch}, 32'h0000_0001);
    wr(ADDR_SWITCH, 32'h0000_0000);
    chk("switch off", {30'h0, integrator_enable_switch}, 32'h0000_0000);
  endtask : t_regs

  task automatic t_depth();
    wr(ADDR_DEPTH, 32'h0000_0007);
    rchk("timer 7", ADDR_TIMER, 32'h0210_0200);
    wr(ADDR_DEPTH, 32'h0000_000D);
    rchk("timer 13", ADDR_TIMER, 32'h8010_8000);
    wr(ADDR_DEPTH, 32'h0000_000E);
    rchk("depth hi", ADDR_DEPTH, 32'h0000_000D);
    wr(ADDR_DEPTH, 32'h0000_0007);
    wr(ADDR_DEPTH, 32'h0000_0006);
    rchk("depth lo", ADDR_DEPTH, 32'h0000_0007);
    wr(ADDR_CALC, 32'h0000_0040);
    rchk("timer calc", ADDR_TIMER, 32'h0240_0200);
  endtask : t_depth

  // full scale high gives +64, full scale low -64, at 7 bits
  task automatic t_count();
    comparator_in <= 2'b01;
    repeat (4) @(posedge aclk);
    wr(ADDR_ACQUIRE, 32'h0000_0002);
    chk("converting", {31'h0, converting}, 32'h0000_0001);
    repeat (80) @(posedge aclk);
    chk("switch run", {30'h0, integrator_enable_switch}, 32'h0000_0003);
    wait_flag();
    comparator_in <= 2'b10;
    chk("switch end", {30'h0, integrator_enable_switch}, 32'h0000_0000);
    rchk("status", ADDR_STATUS, 32'h0000_0003);
    rchk("rd1 clr", ADDR_RD1_CLR, 32'h0000_0040);
    rchk("status", ADDR_STATUS, 32'h0000_0002);
    rchk("result2", ADDR_RESULT2, 32'h0000_FFC0);
    wait_flag();
    rchk("result1", ADDR_RESULT1, 32'h0000_FFC0);
    rchk("rd2 clr", ADDR_RD2_CLR, 32'h0000_0040);
    rd(ADDR_STATUS);
    chk("flag", {31'h0, cap_d[0]}, 32'h0000_0000);
    repeat (80) @(posedge aclk);
    chk("stopped", {31'h0, converting}, 32'h0000_0000);
  endtask : t_count

  task automatic t_cont();
    wr(ADDR_ACQUIRE, 32'h0000_0000);
    rd(ADDR_ACQUIRE);
    chk("continuous", {31'h0, cap_d[8]}, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      wait_flag();
      wr(ADDR_CLEAR, 32'h0000_0000);
      rd(ADDR_STATUS);
      chk("cleared", {31'h0, cap_d[0]}, 32'h0000_0000);
    end
    chk("running", {31'h0, converting}, 32'h0000_0001);
    wr(ADDR_DEPTH, 32'h0000_0009);
    repeat (2) @(posedge aclk);
    chk("depth stop", {31'h0, converting}, 32'h0000_0000);
    wr(ADDR_ACQUIRE, 32'h0000_0000);
    chk("restart", {31'h0, converting}, 32'h0000_0001);
    wr(ADDR_ACQUIRE, 32'h0000_0100);
    chk("halted", {31'h0, converting}, 32'h0000_0000);
  endtask : t_cont

  // ****************************************
  // run control
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    comparator_in = 2'b00;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_regs();
    t_depth();
    t_count();
    t_cont();
    wrap_up();
  end

  // the whole run needs about 3000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    wrap_up();
  end
endmodule : adc_ctrl_tb_top
`default_nettype wire
